/* File: design/twsl_pkg.sv */
package twsl_pkg;

  // ----------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam logic [7:0] OFS_OSA  = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_EVT  = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_LINK = 8'h18;

  // ----------------------------------------
  // interface_control field positions
  // ----------------------------------------
  localparam int unsigned CB_FLAG  = 7;
  localparam int unsigned CB_ACKEN = 6;
  localparam int unsigned CB_STA   = 5;
  localparam int unsigned CB_STO   = 4;
  localparam int unsigned CB_WCOL  = 3;
  localparam int unsigned CB_EN    = 2;
  localparam int unsigned CB_IE    = 0;

  // ----------------------------------------
  // event bits, reset values
  // ----------------------------------------
  localparam int unsigned EV_W    = 3;
  localparam int unsigned EV_FLAG = 0;
  localparam int unsigned EV_WAKE = 1;
  localparam int unsigned EV_WCOL = 2;
  localparam logic [7:0]      OSA_RST  = 8'h00;
  localparam logic [7:0]      DATA_RST = 8'hFF;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;

  // ----------------------------------------
  // status codes (prescaler bits read zero)
  // ----------------------------------------
  localparam logic [7:0] ST_NONE    = 8'hF8;
  localparam logic [7:0] ST_SR_OWN  = 8'h60;
  localparam logic [7:0] ST_SR_ARB  = 8'h68;
  localparam logic [7:0] ST_SR_GC   = 8'h70;
  localparam logic [7:0] ST_TX_OWN  = 8'hA8;
  localparam logic [7:0] ST_TX_ARB  = 8'hB0;
  localparam logic [7:0] ST_TX_ACK  = 8'hB8;
  localparam logic [7:0] ST_TX_NACK = 8'hC0;
  localparam logic [7:0] ST_TX_LAST = 8'hC8;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    S_IDLE     = 3'h0,
    S_ADDR     = 3'h1,
    S_ADDR_ACK = 3'h3,
    S_HOLD     = 3'h2,
    S_TX_BIT   = 3'h6,
    S_TX_ACK   = 3'h7,
    S_IGNORE   = 3'h5
  } twsl_state_e;

endpackage

/* File: design/twsl_pin_sync.sv */
`timescale 1ns/10ps
module twsl_pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_s,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  import twsl_pkg::*;

  // ----------------------------------------
  // two-stage synchronisers, one per pin
  // ----------------------------------------
  logic [1:0] pin_in;
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic [1:0] dly_reg;

  assign pin_in = {sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      // first stage feeds only the second one
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_reg[gi] <= 1'b1;
          sync_reg[gi] <= 1'b1;
          dly_reg[gi]  <= 1'b1;
        end
        else
        begin
          meta_reg[gi] <= pin_in[gi];
          sync_reg[gi] <= meta_reg[gi];
          dly_reg[gi]  <= sync_reg[gi];
        end
      end
    end
  endgenerate

  // edges and bus conditions seen from the synced levels
  assign scl_s     = sync_reg[0];
  assign sda_s     = sync_reg[1];
  assign scl_rise  = sync_reg[0] & ~dly_reg[0];
  assign scl_fall  = ~sync_reg[0] & dly_reg[0];
  assign start_det = sync_reg[0] & dly_reg[0] & dly_reg[1] & ~sync_reg[1];
  assign stop_det  = sync_reg[0] & dly_reg[0] & ~dly_reg[1] & sync_reg[1];

endmodule

/* File: design/twsl_slave_tx.sv */
// What this block does
// (R1) own address with read bit enters transmit mode; write bit only reports receive status, then ignores the bus
// (R2) upper seven bits of own_slave_address are the matched bus address
// (R3) address bit zero set enables answering general call 0x00
// (R4) software sets enable and ack enable, clears start and stop first
// (R5) after address and direction, set interrupt flag with valid status
// (R6) 0xA8: software loads byte; ack enable picks last or more bytes
// (R7) read-addressed after lost arbitration: acknowledge, report 0xB0
// (R8) byte sent and acknowledged reports 0xB8, waits for next byte
// (R9) ack enable cleared sends last byte; 0xC0 on nack, 0xC8 on ack
// (R10) after last byte ignore master clocks; master reads all ones
// (R11) ack enable zero: do not answer own address, keep watching bus
// (R12) in deep sleep, still match address and wake the part
// (R13) after wake-up on a read address hold SCL low until software clears the flag
// (R14) data register need not hold the bus byte after wake-up
// (R15) software compares status with prescaler bits zero
// (R16) software answers each state with stop zero and flag one
// (R17) in 0xC0/0xC8, start request and ack enable pick next behaviour; a start request here only sets spend_reg, read at OFS_LINK, until a stop
// (R18) bytes leave msb first; master acknowledge sampled on ninth clock
`timescale 1ns/10ps
module twsl_slave_tx (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [twsl_pkg::AW-1:0] paddr,
  input  wire logic [twsl_pkg::DW-1:0] pwdata,
  output logic      [twsl_pkg::DW-1:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    scl_i,
  output logic                         scl_o,
  output logic                         scl_oe,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe,
  input  wire logic                    deep_sleep,
  input  wire logic                    arb_lost,
  output logic                         wake_req,
  output logic                         irq
);
  import twsl_pkg::*;

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

  twsl_pin_sync twsl_pin_sync_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  twsl_state_e     state_reg, state_next;
  logic [3:0]      cnt_reg, cnt_next;
  logic [7:0]      sh_reg, sh_next;
  logic            last_reg, last_next, ack_reg, ack_next;
  logic            rd_reg, rd_next, arb_reg, arb_next;
  logic            scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic            wake_reg, wake_next;
  logic            flag_set, wake_set, data_cap;
  logic [7:0]      set_code;
  logic [7:0]      osa_reg, osa_next, data_reg, data_next;
  logic [7:0]      code_reg, code_next;
  logic            flag_reg, flag_next, acken_reg, acken_next;
  logic            sta_reg, sta_next, sto_reg, sto_next;
  logic            en_reg, en_next, ie_reg, ie_next, wcol_reg, wcol_next;
  logic            spend_reg, spend_next;
  logic [EV_W-1:0] evt_reg, evt_next, mask_reg, mask_next;
  logic            irq_reg, irq_next;
  logic [DW-1:0]   prdata_reg, prdata_next;
  logic            pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic            own_hit, gc_hit, wr_en, rd_en, wcol_set;
  logic [7:0]      stat_rd;

  // address compare on the received byte
  assign own_hit = sh_reg[7:1] == osa_reg[7:1];                       // R2
  assign gc_hit  = sh_reg[7:1] == 7'h00 && osa_reg[0] && !sh_reg[0];  // R3

  // ----------------------------------------
  // link state machine
  // ----------------------------------------
  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    sh_next     = sh_reg;
    last_next   = last_reg;
    ack_next    = ack_reg;
    rd_next     = rd_reg;
    arb_next    = arb_reg | arb_lost;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    wake_next   = wake_reg & deep_sleep;
    flag_set    = 1'b0;
    wake_set    = 1'b0;
    data_cap    = 1'b0;
    set_code    = code_reg;
    if (!en_reg)
    begin
      state_next  = S_IDLE;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
    end
    else if (start_det)
    begin
      state_next  = S_ADDR;
      cnt_next    = 4'h0;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
    end
    else if (stop_det)
    begin
      state_next  = S_IDLE;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE, S_IGNORE:
        begin
          sda_oe_next = 1'b0;                                         // R10
        end
        S_ADDR:
        begin
          if (scl_rise)
          begin
            sh_next  = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == BITS_PER_BYTE)
          begin
            // ack enable low isolates the slave but keeps it watching
            if (acken_reg && (own_hit || gc_hit))                     // R11
            begin
              state_next  = S_ADDR_ACK;
              sda_oe_next = 1'b1;
              rd_next     = sh_reg[0];                                // R1
              if (deep_sleep)
                wake_set = 1'b1;                                      // R12
            end
            else
              state_next = S_IGNORE;
          end
        end
        S_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe_next = 1'b0;
            flag_set    = 1'b1;                                       // R5
            arb_next    = 1'b0;
            // the bus byte is not kept while the core clock sleeps
            data_cap    = !deep_sleep;                                // R14
            if (rd_reg)
            begin
              set_code    = arb_reg ? ST_TX_ARB : ST_TX_OWN;          // R7
              state_next  = S_HOLD;
              scl_oe_next = 1'b1;                                     // R13
            end
            else
            begin
              // receive mode itself is not carried out here
              set_code   = gc_hit ? ST_SR_GC
                         : (arb_reg ? ST_SR_ARB : ST_SR_OWN);         // R1
              state_next = S_IGNORE;
            end
          end
        end
        S_HOLD:
        begin
          // clock stretched until software clears the flag
          scl_oe_next = 1'b1;                                         // R13
          if (!flag_reg)
          begin
            sh_next     = data_reg;
            last_next   = !acken_reg;                                 // R6
            sda_oe_next = !data_reg[7];                               // R18
            cnt_next    = 4'h0;
            scl_oe_next = 1'b0;
            state_next  = S_TX_BIT;
          end
        end
        S_TX_BIT:
        begin
          if (scl_rise)
            cnt_next = cnt_reg + 4'h1;
          else if (scl_fall)
          begin
            if (cnt_reg == BITS_PER_BYTE)
            begin
              sda_oe_next = 1'b0;
              state_next  = S_TX_ACK;
            end
            else
            begin
              sh_next     = {sh_reg[6:0], 1'b0};
              sda_oe_next = !sh_reg[6];                               // R18
            end
          end
        end
        S_TX_ACK:
        begin
          if (scl_rise)
            ack_next = !sda_s;                                        // R18
          else if (scl_fall)
          begin
            flag_set = 1'b1;
            if (!ack_reg)
            begin
              set_code   = ST_TX_NACK;                                // R9
              state_next = S_IGNORE;
            end
            else if (last_reg)
            begin
              set_code   = ST_TX_LAST;                                // R9
              state_next = S_IGNORE;                                  // R10
            end
            else
            begin
              set_code    = ST_TX_ACK;                                // R8
              state_next  = S_HOLD;
              scl_oe_next = 1'b1;
            end
          end
        end
        default:
        begin
          state_next  = S_IDLE;
          sda_oe_next = 1'b0;
          scl_oe_next = 1'b0;
        end
      endcase
    end
    if (wake_set)
      wake_next = 1'b1;
  end

  // link state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg  <= S_IDLE;
      cnt_reg    <= 4'h0;
      sh_reg     <= 8'h00;
      last_reg   <= 1'b0;
      ack_reg    <= 1'b0;
      rd_reg     <= 1'b0;
      arb_reg    <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wake_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      sh_reg     <= sh_next;
      last_reg   <= last_next;
      ack_reg    <= ack_next;
      rd_reg     <= rd_next;
      arb_reg    <= arb_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      wake_reg   <= wake_next;
    end
  end

  // ----------------------------------------
  // apb registers, one wait state per access
  // ----------------------------------------
  assign wr_en    = psel & penable & pready_reg & pwrite;
  assign rd_en    = psel & penable & pready_reg & !pwrite;
  assign wcol_set = wr_en && paddr == OFS_DATA && !flag_reg;
  // status reads the idle code whenever the flag is low
  assign stat_rd  = flag_reg ? {code_reg[7:3], 3'h0} : ST_NONE;       // R15

  always_comb
  begin
    osa_next     = osa_reg;
    data_next    = data_reg;
    code_next    = flag_set ? set_code : code_reg;
    flag_next    = flag_reg;
    acken_next   = acken_reg;
    sta_next     = sta_reg;
    sto_next     = sto_reg;
    en_next      = en_reg;
    ie_next      = ie_reg;
    wcol_next    = wcol_reg | wcol_set;
    spend_next   = spend_reg & !stop_det;
    mask_next    = mask_reg;
    evt_next     = evt_reg;
    prdata_next  = prdata_reg;
    pready_next  = psel & penable & !pready_reg;
    pslverr_next = 1'b0;
    if (wr_en)
    begin
      unique case (paddr)
        OFS_OSA:  osa_next = pwdata[7:0];
        OFS_CTRL:
        begin
          acken_next = pwdata[CB_ACKEN];                              // R4
          sta_next   = pwdata[CB_STA];
          sto_next   = pwdata[CB_STO];                                // R16
          en_next    = pwdata[CB_EN];
          ie_next    = pwdata[CB_IE];
          if (pwdata[CB_FLAG])
          begin
            flag_next = 1'b0;
            if (pwdata[CB_STA] && (code_reg == ST_TX_NACK
                || code_reg == ST_TX_LAST))
              spend_next = 1'b1;                                      // R17
          end
        end
        OFS_DATA:
        begin
          if (flag_reg)
          begin
            data_next = pwdata[7:0];                                  // R6
            wcol_next = 1'b0;
          end
        end
        OFS_MASK: mask_next = pwdata[EV_W-1:0];
        default:  ;
      endcase
    end
    if (rd_en && paddr == OFS_EVT)
      evt_next = '0;
    // a hardware set in the same cycle wins over any clear
    if (flag_set)
      flag_next = 1'b1;
    if (data_cap)
      data_next = sh_reg;
    evt_next[EV_FLAG] = evt_next[EV_FLAG] | flag_set;
    evt_next[EV_WAKE] = evt_next[EV_WAKE] | wake_set;
    evt_next[EV_WCOL] = evt_next[EV_WCOL] | wcol_set;
    irq_next = |(evt_next & mask_next);
    if (psel && penable && !pready_reg)
    begin
      prdata_next = '0;
      unique case (paddr)
        OFS_OSA:  prdata_next[7:0] = osa_reg;
        OFS_CTRL: prdata_next[7:0] = {flag_reg, acken_reg, sta_reg,
                                      sto_reg, wcol_reg, en_reg,
                                      1'b0, ie_reg};
        OFS_STAT: prdata_next[7:0] = stat_rd;
        OFS_DATA: prdata_next[7:0] = data_reg;
        OFS_EVT:  prdata_next[EV_W-1:0] = evt_reg;
        OFS_MASK: prdata_next[EV_W-1:0] = mask_reg;
        OFS_LINK: prdata_next[2:0] = {deep_sleep, wake_reg, spend_reg};
        default:  pslverr_next = 1'b1;
      endcase
    end
  end

  // register file and bus answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osa_reg     <= OSA_RST;
      data_reg    <= DATA_RST;
      code_reg    <= ST_NONE;
      flag_reg    <= 1'b0;
      acken_reg   <= 1'b0;
      sta_reg     <= 1'b0;
      sto_reg     <= 1'b0;
      en_reg      <= 1'b0;
      ie_reg      <= 1'b0;
      wcol_reg    <= 1'b0;
      spend_reg   <= 1'b0;
      evt_reg     <= '0;
      mask_reg    <= MASK_RST;
      irq_reg     <= 1'b0;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      osa_reg     <= osa_next;
      data_reg    <= data_next;
      code_reg    <= code_next;
      flag_reg    <= flag_next;
      acken_reg   <= acken_next;
      sta_reg     <= sta_next;
      sto_reg     <= sto_next;
      en_reg      <= en_next;
      ie_reg      <= ie_next;
      wcol_reg    <= wcol_next;
      spend_reg   <= spend_next;
      evt_reg     <= evt_next;
      mask_reg    <= mask_next;
      irq_reg     <= irq_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // open-drain pins only ever pull low
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe   = scl_oe_reg;
  assign sda_oe   = sda_oe_reg;
  assign wake_req = wake_reg;
  assign irq      = irq_reg;
  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_read_enters_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_ADDR_ACK && scl_fall && rd_reg && en_reg && !start_det
    && !stop_det |=> state_reg == S_HOLD && scl_oe_reg) // R1
    else $error("read address did not enter hold");
  a_own_addr_ack: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_ADDR && scl_fall && cnt_reg == 4'h8 && own_hit
    && acken_reg && en_reg && !start_det && !stop_det
    |=> state_reg == S_ADDR_ACK ##0 sda_oe_reg) // R2
    else $error("own address not acknowledged");
  a_gc_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_ADDR && scl_fall && sh_reg[7:1] == 7'h00
    && !osa_reg[0] && osa_reg[7:1] != 7'h00
    |=> state_reg != S_ADDR_ACK) // R3
    else $error("general call answered while disabled");
  a_flag_code: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flag_reg) |-> stat_rd != ST_NONE && evt_reg[EV_FLAG]) // R5
    else $error("flag set without status code");
  a_last_choice: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_HOLD && !flag_reg && en_reg && !start_det && !stop_det
    |=> state_reg == S_TX_BIT && last_reg == !$past(acken_reg)) // R6
    else $error("last byte choice wrong");
  a_arb_code: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_ADDR_ACK && scl_fall && rd_reg && arb_reg && en_reg
    && !start_det && !stop_det |=> code_reg == ST_TX_ARB) // R7
    else $error("lost arbitration code missing");
  a_ack_more: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_TX_ACK && scl_fall && ack_reg && !last_reg && en_reg
    && !start_det && !stop_det |=> code_reg == ST_TX_ACK && flag_reg
    ##1 scl_oe_reg) // R8
    else $error("acknowledged byte not reported");
  a_last_codes: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_TX_ACK && scl_fall && (last_reg || !ack_reg) && en_reg
    && !start_det && !stop_det |=> state_reg == S_IGNORE
    && code_reg == (ack_reg ? ST_TX_LAST : ST_TX_NACK)) // R9
    else $error("last byte end code wrong");
  a_ignore_released: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_IGNORE |=> !sda_oe_reg) // R10
    else $error("sda driven while not addressed");
  a_stretch_flag: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_HOLD && flag_reg |-> scl_oe_reg) // R13
    else $error("scl released before flag cleared");

endmodule

/* File: bench/twsl_master_model.sv */
`timescale 1ns/10ps
module twsl_master_model (
  output logic      scl_m,
  output logic      sda_m,
  input  wire logic scl,
  input  wire logic sda
);
  // ----------------------------------------
  // master receiver on the two-wire bus
  // ----------------------------------------
  localparam int HALF = 32;  // 64 ns link clock
  // lines released at time zero, pull-ups give idle high
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // release scl and wait out any stretch, bounded
  task automatic high_scl();
    int n;
    scl_m = 1'b1;
    for (n = 0; n < 4000 && scl !== 1'b1; n++)
      #1;
    if (n == 4000)
    begin
      twowire_slave_transmitter_test.error_cnt++;
      twowire_slave_transmitter_test.close_out();
    end
    #HALF;
  endtask
  // sda moves well after scl falls so no false start or stop is seen
  task automatic bit_io(input logic b, output logic s);
    #8;
    sda_m = b;
    #(HALF - 8);
    high_scl();
    s = sda;
    scl_m = 1'b0;
  endtask
  task automatic start();
    sda_m = 1'b0;
    #HALF;
    scl_m = 1'b0;
  endtask
  task automatic stop();
    #8;
    sda_m = 1'b0;
    #(HALF - 8);
    high_scl();
    sda_m = 1'b1;
    #HALF;
  endtask
  // tx all ones releases sda; ack_bit low acknowledges a read byte
  task automatic xfer(input logic [7:0] tx, input logic ack_bit,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_bit, ack);
  endtask
endmodule

/* File: bench/twowire_slave_transmitter_test.sv */
`timescale 1ns/10ps
module twowire_slave_transmitter_test;
  import twsl_pkg::*;
  // ----------------------------------------
  // signals, bus wires, instances
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic        e;
  } twsl_row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        scl_o, scl_oe, sda_o, sda_oe, deep_sleep, arb_lost;
  logic        wake_req, irq, scl_m, sda_m, scl, sda, e, ack;
  logic [7:0]  paddr, rx;
  logic [31:0] pwdata, prdata, rv;
  int          error_cnt, compares;
  twsl_row_s   rows [7] = '{'{OFS_OSA, {24'h0, OSA_RST}, 1'b0},
    '{OFS_CTRL, 32'h0, 1'b0}, '{OFS_STAT, {24'h0, ST_NONE}, 1'b0},
    '{OFS_DATA, {24'h0, DATA_RST}, 1'b0}, '{OFS_EVT, 32'h0, 1'b0},
    '{OFS_MASK, 32'h0, 1'b0}, '{8'h1C, 32'h0, 1'b1}};
  // open-drain wires with pull-ups
  assign scl = scl_m & ~scl_oe;
  assign sda = sda_m & ~sda_oe;
  twsl_slave_tx twsl_slave_tx_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .deep_sleep(deep_sleep),
    .arb_lost(arb_lost), .wake_req(wake_req), .irq(irq));
  twsl_master_model twsl_master_model_inst (.scl_m(scl_m), .sda_m(sda_m),
    .scl(scl), .sda(sda));
  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task automatic close_out();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      error_cnt++;
    end
  endtask
  // request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read", x, rv);
  endtask
  // flag raised, status code read, sticky event cleared by the read
  task automatic status(input logic [7:0] code,
                        input logic [31:0] ev = 32'h1);
    int n;
    for (n = 0; n < 3000 && irq !== 1'b1; n++)
      @(posedge pclk);
    if (n == 3000)
    begin
      error_cnt++;
      close_out();
    end
    rd(OFS_STAT, {24'h0, code});
    rd(OFS_EVT, ev);
  endtask
  task automatic addr(input logic [7:0] ab, input logic x_ack);
    twsl_master_model_inst.start();
    twsl_master_model_inst.xfer(ab, 1'b1, rx, ack);
    chk("addr ack", {31'h0, x_ack}, {31'h0, ack});
  endtask
  task automatic byte_rd(input logic nak, input logic [7:0] x);
    twsl_master_model_inst.xfer(8'hFF, nak, rx, ack);
    chk("rx byte", {24'h0, x}, {24'h0, rx});
  endtask
  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    #300000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, deep_sleep, arb_lost} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    // reset values and the unmapped slot
    foreach (rows[i])
    begin
      rd(rows[i].a, rows[i].d);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, e});
    end
    apb(1'b1, OFS_OSA, 32'h0000_00A4);
    apb(1'b1, OFS_MASK, 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_0044);
    addr(8'hA7, 1'b1);
    twsl_master_model_inst.stop();
    addr(8'h00, 1'b1);
    twsl_master_model_inst.stop();
    apb(1'b1, OFS_OSA, 32'h0000_00A5);
    addr(8'h00, 1'b0);
    status(ST_SR_GC);
    twsl_master_model_inst.stop();
    addr(8'hA5, 1'b0);
    status(ST_TX_OWN);
    apb(1'b1, OFS_DATA, 32'h0000_0096);
    apb(1'b1, OFS_CTRL, 32'h0000_00C4);
    byte_rd(1'b0, 8'h96);
    status(ST_TX_ACK);
    apb(1'b1, OFS_DATA, 32'h0000_003C);
    apb(1'b1, OFS_CTRL, 32'h0000_0084);
    byte_rd(1'b0, 8'h3C);
    status(ST_TX_LAST);
    apb(1'b1, OFS_CTRL, 32'h0000_00A4);
    // a data write with the flag low is dropped and flagged
    apb(1'b1, OFS_DATA, 32'h0000_0011);
    rd(OFS_EVT, 32'h4);
    byte_rd(1'b0, 8'hFF);
    rd(OFS_LINK, 32'h1);
    twsl_master_model_inst.stop();
    addr(8'hA5, 1'b1);
    twsl_master_model_inst.stop();
    apb(1'b1, OFS_CTRL, 32'h0000_0044);
    // read address after lost arbitration, seen while asleep
    {deep_sleep, arb_lost} <= 2'b11;
    @(posedge pclk);
    arb_lost <= 1'b0;
    addr(8'hA5, 1'b0);
    status(ST_TX_ARB, 32'h3);
    chk("scl_oe", 32'h1, {31'h0, scl_oe});
    chk("wake_req", 32'h1, {31'h0, wake_req});
    rd(OFS_LINK, 32'h6);
    rd(OFS_DATA, 32'h3C);
    deep_sleep <= 1'b0;
    apb(1'b1, OFS_DATA, 32'h0000_005A);
    apb(1'b1, OFS_CTRL, 32'h0000_0084);
    byte_rd(1'b1, 8'h5A);
    status(ST_TX_NACK);
    twsl_master_model_inst.stop();
    repeat (3) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    chk("wake_req", 32'h0, {31'h0, wake_req});
    // reset again in mid-run, own address register back to its reset value
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_OSA, {24'h0, OSA_RST});
    close_out();
  end
endmodule
